// ==== pmicsq_top.sv ====
// Behaviour
// R1: status, charger, battery, converter bits feed interrupts
// R2: mask registers select which bits interrupt
// R3: input-configured general pins interrupt on edges
// R4: set cause latches first, then pull line low
// R5: while line low, latches frozen, changes ignored
// R6: host writes zero to cause, line released
// R7: aborted access keeps line low, no timeout
// R8: new interrupt only after line returns high
// R9: unmasked out-of-regulation bit raises power-good fault
// R10: power-good fault changes operating mode
// R11: below undervoltage, everything disabled and off
// R12: rails active, registers load power-up defaults
// R13: then power path on, flag cleared, enter ENABLE
// R14: ENABLE: reset low, interrupt off, comparators off
// R15: ENABLE until rail sense above threshold
// R16: SEQUENCING turns supplies on, then reset timer
// R17: regulator five and bucks together, bucks need pins
// R18: reset low: ignore sources, driver disabled
// R19: reset timer expiry enters power-good check
// R20: supply below fraction of target flags fault
// R21: toggles found against previous cycle's value
//
// Added by the designer: the address map and the APB slave port.
module pmicsq_top
    import pmicsq_pkg::*;
#(
    parameter int RESET_CYC = RESET_CYCLES,
    parameter int SEQ_CYC   = SEQ_CYCLES
) (
    input  wire logic              CLOCK_IN,
    input  wire logic              RST_B_IN,
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic [7:0]        PADDR_IN,
    input  wire logic [31:0]       PWDATA_IN,
    output logic      [31:0]       PRDATA_OUT,
    output logic                   PREADY_OUT,
    output logic                   PSLVERR_OUT,
    input  wire logic [STAT_W-1:0] STATUS_IN,
    input  wire logic [PG_W-1:0]   PG_LOW_IN,
    input  wire logic              GENERAL_PIN_ONE_IN,
    input  wire logic              GENERAL_PIN_TWO_IN,
    input  wire logic              UVLO_OK_IN,
    input  wire logic              RAILS_ACTIVE_IN,
    input  wire logic              RAIL_SENSE_ABOVE_IN,
    output logic                   INT_O_OUT,
    output logic                   INT_OE_OUT,
    output logic                   SYSTEM_RESET_OUT_N_OUT,
    output logic                   POWER_PATH_EN_OUT,
    output logic                   LINEAR_REG_FIVE_EN_OUT,
    output logic                   BUCK_ONE_EN_OUT,
    output logic                   BUCK_TWO_EN_OUT,
    output logic                   PG_CMP_EN_OUT,
    output logic                   PG_FAULT_OUT
);

    // ****************************************
    // input synchronisers
    // ****************************************
    pmicsq_pins_t pins_raw;
    pmicsq_pins_t pins_s;
    logic [PINS_W-1:0] pins_q;

    assign pins_raw = '{stat: STATUS_IN, pg_low: PG_LOW_IN,
                        general_pin_two: GENERAL_PIN_TWO_IN,
                        general_pin_one: GENERAL_PIN_ONE_IN,
                        uvlo_ok: UVLO_OK_IN, rails_ok: RAILS_ACTIVE_IN,
                        sys_ok: RAIL_SENSE_ABOVE_IN};

    pmicsq_sync #(.W(PINS_W)) u_sync (
        .clk_in   (CLOCK_IN),
        .rst_b_in (RST_B_IN),
        .d_in     (pins_raw),
        .q_out    (pins_q)
    );
    assign pins_s = pmicsq_pins_t'(pins_q);

    // ****************************************
    // state
    // ****************************************
    pmicsq_state_t     state_r,    state_nxt;
    logic [31:0]       timer_r,    timer_nxt;
    logic              sysrst_n_r, sysrst_n_nxt;
    logic              path_r,     path_nxt;
    logic              linear_reg_five_r,     linear_reg_five_nxt;
    logic              buck1_r,    buck1_nxt;
    logic              buck2_r,    buck2_nxt;
    logic              pgcmp_r,    pgcmp_nxt;
    logic              pgflt_r,    pgflt_nxt;
    logic              flag_n_r,   flag_n_nxt;
    logic [STAT_W-1:0] mask_a_r,   mask_a_nxt;
    logic [CB_W-1:0]   mask_b_r,   mask_b_nxt;
    logic [PG_W-1:0]   pgmask_r,   pgmask_nxt;
    logic [PIN_W-1:0]  ctrl_r,     ctrl_nxt;
    logic [STAT_W-1:0] latch_a_r,  latch_a_nxt;
    logic [CB_W-1:0]   latch_b_r,  latch_b_nxt;
    logic [STAT_W-1:0] prev_s_r,   prev_s_nxt;
    logic [PG_W-1:0]   prev_pg_r,  prev_pg_nxt;
    logic [PIN_W-1:0]  prev_pin_r, prev_pin_nxt;
    logic              arm_r,      arm_nxt;
    logic              int_act_r,  int_act_nxt;
    logic [31:0]       prdata_r,   prdata_nxt;
    logic              pready_r,   pready_nxt;
    logic              pslverr_r,  pslverr_nxt;

    // ****************************************
    // interrupt cause detection
    // ****************************************
    logic [PIN_W-1:0]  pin_now;
    logic [PIN_W-1:0]  pin_edge;
    logic [STAT_W-1:0] cause_a;
    logic [CB_W-1:0]   cause_b;
    logic              irq_allow;
    logic              hit;
    logic              wr_en;
    logic              ack_wr;
    logic              mapped;

    always_comb begin
        pin_now   = {pins_s.general_pin_two, pins_s.general_pin_one};
        pin_edge  = (pin_now ^ prev_pin_r) & ctrl_r;                 // [R3]
        cause_a   = (pins_s.stat ^ prev_s_r) & ~mask_a_r;            // [R1] [R2] [R21]
        cause_b   = {pins_s.pg_low ^ prev_pg_r, pin_edge} & ~mask_b_r; // [R2] [R21]
        // line must be high and reset released before a new cause counts
        irq_allow = sysrst_n_r & ~int_act_r & ~arm_r;                // [R5] [R8] [R18]
        hit       = irq_allow & ((|cause_a) | (|cause_b));
        wr_en     = PSEL_IN & PENABLE_IN & pready_r & PWRITE_IN;
        ack_wr    = wr_en & ((PADDR_IN == OFS_LATCH_A) | (PADDR_IN == OFS_LATCH_B));
        mapped    = (PADDR_IN[1:0] == 2'h0) & (PADDR_IN <= OFS_MODE);
    end

    // ****************************************
    // sequencer
    // ****************************************
    logic sup_on;

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        unique case (state_r)
            ST_OFF: begin
                if (pins_s.rails_ok) begin
                    state_nxt = ST_LOAD;                             // [R12]
                end
            end
            ST_LOAD: begin
                state_nxt = ST_ENABLE;                               // [R13]
            end
            ST_ENABLE: begin
                if (pins_s.sys_ok) begin
                    state_nxt = ST_SEQ;                              // [R15]
                    timer_nxt = '0;
                end
            end
            ST_SEQ: begin
                timer_nxt = timer_r + 32'h0000_0001;
                if (timer_r == 32'(SEQ_CYC - 1)) begin
                    state_nxt = ST_RESET;                            // [R16]
                    timer_nxt = '0;
                end
            end
            ST_RESET: begin
                timer_nxt = timer_r + 32'h0000_0001;
                if (timer_r == 32'(RESET_CYC - 1)) begin
                    state_nxt = ST_PGCHK;                            // [R19]
                    timer_nxt = '0;
                end
            end
            ST_PGCHK: begin
                // comparators get two cycles (PGCHK_CYCLES) to settle before the verdict
                timer_nxt = timer_r + 32'h0000_0001;
                if (timer_r == 32'(PGCHK_CYCLES - 1)) begin
                    state_nxt = pgflt_r ? ST_SLEEP : ST_NORMAL;      // [R10]
                end
            end
            ST_NORMAL: begin
                if (pgflt_r) begin
                    state_nxt = ST_OFF;                              // [R10]
                end
            end
            ST_SLEEP: begin
                state_nxt = ST_SLEEP;
            end
        endcase
        if (!pins_s.uvlo_ok) begin
            state_nxt = ST_OFF;                                      // [R11]
            timer_nxt = '0;
        end
        sup_on       = (state_nxt == ST_SEQ) | (state_nxt == ST_RESET) |
                       (state_nxt == ST_PGCHK) | (state_nxt == ST_NORMAL);
        linear_reg_five_nxt     = sup_on;                                       // [R16] [R17]
        buck1_nxt    = sup_on & pins_s.general_pin_one;              // [R17]
        buck2_nxt    = sup_on & pins_s.general_pin_two;              // [R17]
        sysrst_n_nxt = (state_nxt == ST_PGCHK) | (state_nxt == ST_NORMAL); // [R14]
        pgcmp_nxt    = sysrst_n_nxt;                                 // [R14]
        path_nxt     = (state_nxt != ST_OFF) & (state_nxt != ST_LOAD); // [R13] [R11]
        flag_n_nxt   = (state_nxt == ST_OFF) | (state_nxt == ST_LOAD); // [R13]
        // comparator output itself is the below-fraction flag
        pgflt_nxt    = pgcmp_r & (|(pins_s.pg_low & ~pgmask_r));     // [R9] [R20]
    end

    // ****************************************
    // interrupt controller and registers
    // ****************************************
    always_comb begin
        mask_a_nxt   = mask_a_r;
        mask_b_nxt   = mask_b_r;
        pgmask_nxt   = pgmask_r;
        ctrl_nxt     = ctrl_r;
        latch_a_nxt  = latch_a_r;
        latch_b_nxt  = latch_b_r;
        prev_s_nxt   = pins_s.stat;                                  // [R21]
        prev_pg_nxt  = pins_s.pg_low;
        prev_pin_nxt = pin_now;
        // an arm that meets a falling system reset would be left dangling
        arm_nxt      = hit & sysrst_n_nxt;                           // [R18]
        int_act_nxt  = int_act_r;
        if (arm_r) begin
            int_act_nxt = 1'b1;                                      // [R4]
        end
        if (wr_en) begin
            unique case (PADDR_IN)
                OFS_MASK_A:  mask_a_nxt = PWDATA_IN[STAT_W-1:0];     // [R2]
                OFS_MASK_B:  mask_b_nxt = PWDATA_IN[CB_W-1:0];
                OFS_PG_MASK: pgmask_nxt = PWDATA_IN[PG_W-1:0];
                OFS_CTRL:    ctrl_nxt = PWDATA_IN[PIN_W-1:0];
                OFS_LATCH_A: latch_a_nxt = latch_a_r & PWDATA_IN[STAT_W-1:0]; // [R6]
                OFS_LATCH_B: latch_b_nxt = latch_b_r & PWDATA_IN[CB_W-1:0];
                default: begin
                end
            endcase
        end
        // a new cause wins over a clearing write in the same cycle
        if (hit) begin
            latch_a_nxt = latch_a_nxt | cause_a;                     // [R4]
            latch_b_nxt = latch_b_nxt | cause_b;
        end
        // only an acknowledge write or a falling system reset releases the line; no timer does
        if (ack_wr && int_act_r && latch_a_nxt == '0 && latch_b_nxt == '0) begin
            int_act_nxt = 1'b0;                                      // [R6] [R7]
        end
        int_act_nxt = int_act_nxt & sysrst_n_nxt;                    // [R18]
        if (state_r == ST_LOAD) begin
            mask_a_nxt  = MASK_A_RST;                                // [R12]
            mask_b_nxt  = MASK_B_RST;
            pgmask_nxt  = PG_MASK_RST;
            ctrl_nxt    = CTRL_RST;
            latch_a_nxt = '0;
            latch_b_nxt = '0;
        end
    end

    // ****************************************
    // apb slave: one wait-free access phase
    // ****************************************
    always_comb begin
        prdata_nxt  = '0;
        pready_nxt  = PSEL_IN & ~PENABLE_IN;
        pslverr_nxt = PSEL_IN & ~PENABLE_IN & ~mapped;
        if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            unique case (PADDR_IN)
                OFS_MASK_A:  prdata_nxt[STAT_W-1:0] = mask_a_r;
                OFS_MASK_B:  prdata_nxt[CB_W-1:0] = mask_b_r;
                OFS_PG_MASK: prdata_nxt[PG_W-1:0] = pgmask_r;
                OFS_LATCH_A: prdata_nxt[STAT_W-1:0] = latch_a_r;
                OFS_LATCH_B: prdata_nxt[CB_W-1:0] = latch_b_r;
                OFS_STATUS:  prdata_nxt[STAT_W+PG_W-1:0] = {pins_s.pg_low, pins_s.stat};
                OFS_CTRL:    prdata_nxt[PIN_W-1:0] = ctrl_r;
                OFS_MODE: begin
                    prdata_nxt[MODE_STATE_LSB +: 3] = state_r;
                    prdata_nxt[MODE_FLAG_BIT]       = flag_n_r;
                    prdata_nxt[MODE_FAULT_BIT]      = pgflt_r;
                    prdata_nxt[MODE_INT_BIT]        = int_act_r;
                    prdata_nxt[MODE_RST_BIT]        = sysrst_n_r;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_B_IN) begin
            state_r    <= ST_OFF;
            timer_r    <= '0;
            sysrst_n_r <= 1'b0;
            path_r     <= 1'b0;
            linear_reg_five_r     <= 1'b0;
            buck1_r    <= 1'b0;
            buck2_r    <= 1'b0;
            pgcmp_r    <= 1'b0;
            pgflt_r    <= 1'b0;
            flag_n_r   <= 1'b1;
            mask_a_r   <= MASK_A_RST;
            mask_b_r   <= MASK_B_RST;
            pgmask_r   <= PG_MASK_RST;
            ctrl_r     <= CTRL_RST;
            latch_a_r  <= '0;
            latch_b_r  <= '0;
            prev_s_r   <= '0;
            prev_pg_r  <= '0;
            prev_pin_r <= '0;
            arm_r      <= 1'b0;
            int_act_r  <= 1'b0;
            prdata_r   <= '0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            timer_r    <= timer_nxt;
            sysrst_n_r <= sysrst_n_nxt;
            path_r     <= path_nxt;
            linear_reg_five_r     <= linear_reg_five_nxt;
            buck1_r    <= buck1_nxt;
            buck2_r    <= buck2_nxt;
            pgcmp_r    <= pgcmp_nxt;
            pgflt_r    <= pgflt_nxt;
            flag_n_r   <= flag_n_nxt;
            mask_a_r   <= mask_a_nxt;
            mask_b_r   <= mask_b_nxt;
            pgmask_r   <= pgmask_nxt;
            ctrl_r     <= ctrl_nxt;
            latch_a_r  <= latch_a_nxt;
            latch_b_r  <= latch_b_nxt;
            prev_s_r   <= prev_s_nxt;
            prev_pg_r  <= prev_pg_nxt;
            prev_pin_r <= prev_pin_nxt;
            arm_r      <= arm_nxt;
            int_act_r  <= int_act_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
        end
    end

    assign PRDATA_OUT             = prdata_r;
    assign PREADY_OUT             = pready_r;
    assign PSLVERR_OUT            = pslverr_r;
    assign INT_O_OUT              = 1'b0;
    assign INT_OE_OUT             = int_act_r;
    assign SYSTEM_RESET_OUT_N_OUT = sysrst_n_r;
    assign POWER_PATH_EN_OUT      = path_r;
    assign LINEAR_REG_FIVE_EN_OUT = linear_reg_five_r;
    assign BUCK_ONE_EN_OUT        = buck1_r;
    assign BUCK_TWO_EN_OUT        = buck2_r;
    assign PG_CMP_EN_OUT          = pgcmp_r;
    assign PG_FAULT_OUT           = pgflt_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_B_IN);

    sequence s_cause;
        hit ##1 (arm_r && !int_act_r && ((|latch_a_r) || (|latch_b_r)));
    endsequence

    cause_first_a: assert property (s_cause |=> (int_act_r || !sysrst_n_r)) // [R4]
        else $error("cause latched without line going low");
    latch_frozen_a: assert property ((int_act_r && !ack_wr && state_r != ST_LOAD) // [R5]
        |=> $stable(latch_a_r) && $stable(latch_b_r))
        else $error("cause latch changed while line low");
    ack_release_a: assert property ((ack_wr && int_act_r && latch_a_nxt == '0 // [R6]
        && latch_b_nxt == '0) |=> !int_act_r)
        else $error("line not released after acknowledge");
    no_timeout_a: assert property ((int_act_r && !ack_wr) ##1 sysrst_n_r |-> int_act_r) // [R7]
        else $error("line released without acknowledge");
    reset_quiet_a: assert property (!sysrst_n_r |-> !int_act_r && !arm_r) // [R18]
        else $error("interrupt driven while reset low");
    enable_out_a: assert property (state_r == ST_ENABLE |-> !sysrst_n_r && !pgcmp_r // [R14]
        && !int_act_r && path_r && !flag_n_r)
        else $error("enable state outputs wrong");
    seq_end_a: assert property ((state_r == ST_SEQ && timer_r == 32'(SEQ_CYC - 1)) // [R16]
        |=> (state_r == ST_RESET && timer_r == '0) || state_r == ST_OFF)
        else $error("sequencing did not start reset timer");
    buck_pair_a: assert property ((buck1_r || buck2_r) |-> linear_reg_five_r) // [R17]
        else $error("buck on without regulator five");
    pg_fault_a: assert property ((pgcmp_r && (|(pins_s.pg_low & ~pgmask_r))) // [R9]
        |=> pgflt_r)
        else $error("power-good fault missed");
    uvlo_off_a: assert property (!pins_s.uvlo_ok |=> state_r == ST_OFF && !linear_reg_five_r // [R11]
        && !path_r)
        else $error("functions active below undervoltage");

endmodule

// ==== pmicsq_pkg.sv ====
package pmicsq_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int STAT_W = 16;
    localparam int PG_W   = 8;
    localparam int PIN_W  = 2;
    localparam int CB_W   = PG_W + PIN_W;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_MASK_A  = 8'h00;
    localparam logic [7:0] OFS_MASK_B  = 8'h04;
    localparam logic [7:0] OFS_PG_MASK = 8'h08;
    localparam logic [7:0] OFS_LATCH_A = 8'h0C;
    localparam logic [7:0] OFS_LATCH_B = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_CTRL    = 8'h18;
    localparam logic [7:0] OFS_MODE    = 8'h1C;

    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [STAT_W-1:0] MASK_A_RST  = 16'h0000;
    localparam logic [CB_W-1:0]   MASK_B_RST  = 10'h000;
    localparam logic [PG_W-1:0]   PG_MASK_RST = 8'hFF;
    localparam logic [PIN_W-1:0]  CTRL_RST    = 2'h3;
    localparam int MODE_STATE_LSB = 0;
    localparam int MODE_FLAG_BIT  = 4;
    localparam int MODE_FAULT_BIT = 5;
    localparam int MODE_INT_BIT   = 6;
    localparam int MODE_RST_BIT   = 7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ       = 125;
    localparam int SEQ_TIME_NS   = 2000;
    localparam int SEQ_CYCLES    = (SEQ_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_TIME_US = 1000;
    localparam int RESET_CYCLES  = RESET_TIME_US * CLK_MHZ;
    localparam int PGCHK_CYCLES  = 2;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_LOAD   = 3'b001,
        ST_ENABLE = 3'b010,
        ST_SEQ    = 3'b011,
        ST_RESET  = 3'b100,
        ST_PGCHK  = 3'b101,
        ST_NORMAL = 3'b110,
        ST_SLEEP  = 3'b111
    } pmicsq_state_t;

    typedef struct packed {
        logic [STAT_W-1:0] stat;
        logic [PG_W-1:0]   pg_low;
        logic              general_pin_two;
        logic              general_pin_one;
        logic              uvlo_ok;
        logic              rails_ok;
        logic              sys_ok;
    } pmicsq_pins_t;

    localparam int PINS_W = $bits(pmicsq_pins_t);

endpackage

// ==== pmicsq_sync.sv ====
module pmicsq_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // first stage feeds only the second stage
    always_comb begin
        meta_nxt = rst_b_in ? d_in : '0;
        q_nxt    = rst_b_in ? meta_r : '0;
    end

    always_ff @(posedge clk_in) begin
        meta_r <= meta_nxt;
        q_r    <= q_nxt;
    end

    assign q_out = q_r;

endmodule

// ==== pmicsq_host.sv ====
// ****************************************
// host model: apb master and pulled-up line
// ****************************************
module pmicsq_host (
    input  wire logic        clk_in,
    input  wire logic        pready_in,
    input  wire logic        int_oe_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [7:0]       paddr_out,
    output logic [31:0]      pwdata_out,
    output logic             int_line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hang;

    // open drain with pull-up: high unless the device pulls low
    assign int_line_out = !int_oe_in;

    initial begin
        hang        = 1'b0;
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 8'h00;
        pwdata_out  = 32'h0000_0000;
    end

    // request held until pready is seen; bounded so a dead slave cannot hang us
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out  <= w;
        paddr_out   <= a;
        pwdata_out  <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 50);
        if (n >= 50) hang = 1'b1;
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        pwdata_out  <= ~d;
    endtask
endmodule

// ==== pmicsq_top_bench.sv ====
module pmicsq_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pmicsq_pkg::*;
    typedef struct packed { logic rd; logic [31:0] d; logic e; } pmicsq_note_t;
    logic CLOCK_IN = 1'b0, RST_B_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT;
    logic [7:0]        PADDR_IN;
    logic [31:0]       PWDATA_IN, PRDATA_OUT;
    logic [STAT_W-1:0] STATUS_IN;
    logic [PG_W-1:0]   PG_LOW_IN;
    logic GENERAL_PIN_ONE_IN, GENERAL_PIN_TWO_IN, UVLO_OK_IN, RAILS_ACTIVE_IN;
    logic RAIL_SENSE_ABOVE_IN, INT_O_OUT, INT_OE_OUT, SYSTEM_RESET_OUT_N_OUT, int_line;
    logic POWER_PATH_EN_OUT, LINEAR_REG_FIVE_EN_OUT, BUCK_ONE_EN_OUT, BUCK_TWO_EN_OUT;
    logic PG_CMP_EN_OUT, PG_FAULT_OUT;
    pmicsq_note_t q[$];
    int n_fail = 0, checks = 0, seed = 27843, b;
    always #4 CLOCK_IN = ~CLOCK_IN;
    pmicsq_top #(.RESET_CYC(20), .SEQ_CYC(4)) u_pmicsq_top (.*);
    pmicsq_host u_pmicsq_host (.clk_in(CLOCK_IN), .pready_in(PREADY_OUT),
        .int_oe_in(INT_OE_OUT), .psel_out(PSEL_IN), .penable_out(PENABLE_IN),
        .pwrite_out(PWRITE_IN), .paddr_out(PADDR_IN), .pwdata_out(PWDATA_IN),
        .int_line_out(int_line));
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run();
        if (u_pmicsq_host.hang) n_fail++;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic sig(input int id);
        case (id)
            0: return POWER_PATH_EN_OUT;
            1: return LINEAR_REG_FIVE_EN_OUT;
            2: return SYSTEM_RESET_OUT_N_OUT;
            3: return INT_OE_OUT;
            default: return PG_FAULT_OUT;
        endcase
    endfunction
    // outputs are looked at on the falling edge, where they have settled
    task automatic waitsig(input int id, input logic v);
        int k;
        for (k = 0; k < 300 && sig(id) !== v; k++) @(negedge CLOCK_IN);
        cmp($sformatf("output %0d", id), {31'h0, v}, {31'h0, sig(id)});
        if (k == 300) complete_run();
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] ed, input logic ee);
        q.push_back('{rd: !w, d: ed, e: ee});
        u_pmicsq_host.apb(w, a, d);
        if (u_pmicsq_host.hang) complete_run();
    endtask
    // ****************************************
    // watcher: oldest note against each answer
    // ****************************************
    always @(posedge CLOCK_IN) begin
        if (PREADY_OUT === 1'b1 && PSEL_IN && PENABLE_IN) begin
            if (q.size() == 0) cmp("queue", 32'h1, 32'h0);
            else if (q[0].rd) cmp("prdata", q[0].d, PRDATA_OUT);
            if (q.size() != 0) cmp("pslverr", {31'h0, q[0].e}, {31'h0, PSLVERR_OUT});
            if (q.size() != 0) void'(q.pop_front());
        end
    end
    initial begin
        {RST_B_IN, STATUS_IN, PG_LOW_IN, GENERAL_PIN_ONE_IN, GENERAL_PIN_TWO_IN} = '0;
        {UVLO_OK_IN, RAILS_ACTIVE_IN, RAIL_SENSE_ABOVE_IN} = 3'h0;
        repeat (10) @(posedge CLOCK_IN);
        RST_B_IN <= 1'b1;
        repeat (6) @(negedge CLOCK_IN);
        cmp("path off", 32'h0, {31'h0, POWER_PATH_EN_OUT});
        @(posedge CLOCK_IN);
        UVLO_OK_IN      <= 1'b1;
        RAILS_ACTIVE_IN <= 1'b1;
        waitsig(0, 1'b1);
        repeat (10) @(negedge CLOCK_IN);
        cmp("enable", 32'h0, {29'h0, SYSTEM_RESET_OUT_N_OUT, INT_OE_OUT, PG_CMP_EN_OUT});
        cmp("ldo held", 32'h0, {31'h0, LINEAR_REG_FIVE_EN_OUT});
        @(posedge CLOCK_IN);
        RAIL_SENSE_ABOVE_IN <= 1'b1;
        GENERAL_PIN_ONE_IN  <= 1'b1;
        waitsig(1, 1'b1);
        cmp("bucks", {30'h0, BUCK_ONE_EN_OUT, BUCK_TWO_EN_OUT}, 32'h2);
        waitsig(2, 1'b1);
        cmp("comparators", 32'h1, {31'h0, PG_CMP_EN_OUT});
        $display("test power_up done");
        xfer(0, OFS_MASK_A, 0, 32'h0, 0);
        xfer(0, OFS_PG_MASK, 0, 32'hFF, 0);
        xfer(0, OFS_CTRL, 0, 32'h3, 0);
        xfer(0, OFS_MODE, 0, 32'h86, 0);
        xfer(0, 8'h20, 0, 32'h0, 1);
        $display("test registers done");
        b = $unsigned($random(seed)) % 16;
        @(posedge CLOCK_IN);
        STATUS_IN <= 16'h1 << b;
        waitsig(3, 1'b1);
        cmp("line", 32'h0, {31'h0, int_line});
        cmp("int data", 32'h0, {31'h0, INT_O_OUT});
        xfer(0, OFS_LATCH_A, 0, 32'h1 << b, 0);
        STATUS_IN <= 16'hFFFF;
        repeat (8) @(posedge CLOCK_IN);
        xfer(0, OFS_LATCH_A, 0, 32'h1 << b, 0);
        xfer(1, OFS_LATCH_A, 0, 0, 0);
        waitsig(3, 1'b0);
        repeat (8) @(negedge CLOCK_IN);
        cmp("no requeue", 32'h0, {31'h0, INT_OE_OUT});
        xfer(1, OFS_MASK_A, 32'h1 << b, 0, 0);
        STATUS_IN <= STATUS_IN ^ (16'h1 << b);
        repeat (8) @(negedge CLOCK_IN);
        cmp("masked", 32'h0, {31'h0, INT_OE_OUT});
        $display("test status_irq done");
        @(posedge CLOCK_IN);
        GENERAL_PIN_TWO_IN <= 1'b1;
        waitsig(3, 1'b1);
        xfer(0, OFS_LATCH_B, 0, 32'h2, 0);
        xfer(1, OFS_LATCH_B, 0, 0, 0);
        waitsig(3, 1'b0);
        $display("test pin_irq done");
        xfer(1, OFS_PG_MASK, 32'hFE, 0, 0);
        PG_LOW_IN <= 8'h01;
        waitsig(4, 1'b1);
        waitsig(0, 1'b0);
        cmp("reset low", 32'h0, {31'h0, SYSTEM_RESET_OUT_N_OUT});
        $display("test pg_fault done");
        complete_run();
    end
endmodule
